// ===== common/hall_pkg.sv
package hall_pkg;

  // register offsets of the read port
  localparam logic [15:0] OFS_SWITCH_U    = 16'h03A4;
  localparam logic [15:0] OFS_SWITCH_V    = 16'h03A6;
  localparam logic [15:0] OFS_SWITCH_W    = 16'h03A8;
  localparam logic [15:0] OFS_FB_TYPE     = 16'h011C;
  localparam logic [15:0] OFS_PACKED      = 16'h03A0;
  localparam logic [15:0] OFS_TEXT_LO     = 16'h03AA;
  localparam logic [15:0] OFS_TEXT_HI     = 16'h03AC;

  // field layout and reset values
  localparam int          DATA_W          = 32;
  localparam int          TYPE_W          = 8;
  localparam int          TEXT_W          = 40;
  localparam logic [7:0]  LEVEL_RESET     = 8'h01;
  localparam logic [2:0]  PACKED_RESET    = 3'h0;
  localparam int          BIT_U           = 0;
  localparam int          BIT_V           = 1;
  localparam int          BIT_W           = 2;

  // feedback type codes
  localparam logic [7:0]  TYPE_UNKNOWN    = 8'h00;
  localparam logic [7:0]  TYPE_INC_HALL   = 8'h0A;
  localparam logic [7:0]  TYPE_INC_NOHALL = 8'h0B;
  localparam logic [7:0]  TYPE_SINE_HALL  = 8'h14;
  localparam logic [7:0]  TYPE_SELECT_NONE = 8'hFF;

  // text form characters
  localparam logic [7:0]  CHAR_ZERO       = 8'h30;
  localparam logic [7:0]  CHAR_SPACE      = 8'h20;

  // a hall word of 000 or 111 cannot occur on a healthy motor
  localparam logic [2:0]  HALL_ALL_LOW    = 3'h0;
  localparam logic [2:0]  HALL_ALL_HIGH   = 3'h7;

endpackage : hall_pkg

// ===== rtl/hall_sensor_state_readout.sv
// What this block does
// RQ1: packed value weights U by 1, V by 2, W by 4.
// RQ2: an inactive switch adds zero; all inactive reads zero.
// RQ3: packed reading is one unsigned integer from zero to seven.
// RQ4: text form is three binary digits, U then V then W.
// RQ5: a digit is 0 for a low level and 1 for a high level.
// RQ6: hall readings apply only to encoder feedback types with hall switches.
// RQ7: read-only register gives switch U level alone, zero or one.
// RQ8: separate read-only registers give switch V and switch W levels.
// RQ9: read-only integer names the attached feedback device type.
// RQ10: type codes 10, 11 and 20 for the encoder kinds.
// RQ11: at power up take selection unless it is -1, else stored value.
// RQ12: each hall input passes a two-stage synchroniser first.
`timescale 1ns/100ps
`default_nettype none

module hall_sensor_state_readout
  import hall_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              hall_u,
  input  wire logic              hall_v,
  input  wire logic              hall_w,
  input  wire logic [TYPE_W-1:0] feedback_type_selection,
  input  wire logic [TYPE_W-1:0] stored_feedback_type,
  input  wire logic              rd_en,
  input  wire logic [15:0]       rd_addr,
  output logic      [DATA_W-1:0] rd_data,
  output logic                   rd_valid,
  output logic                   rd_error,
  output logic      [2:0]        packed_commutation_switches,
  output logic      [TEXT_W-1:0] hall_text,
  output logic      [7:0]        switch_u_level,
  output logic      [7:0]        switch_v_level,
  output logic      [7:0]        switch_w_level,
  output logic      [TYPE_W-1:0] feedback_type_code,
  output logic                   hall_info_valid,
  output logic                   hall_changed,
  output logic                   hall_illegal
);

  // synchronised pin word, switch U in bit zero
  logic [2:0] hall_sync;

  // pins come from outside the clock domain
  hall_sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .async_in ({hall_w, hall_v, hall_u}),
    .sync_out (hall_sync)
  ); // [RQ12]

  // weighted sum of the three switches
  function automatic logic [2:0] pack_halls(input logic u, input logic v, input logic w);
    logic [2:0] sum;
    sum = 3'h0;
    if (u) sum = sum + 3'h1; // [RQ1] [RQ2]
    if (v) sum = sum + 3'h2; // [RQ1]
    if (w) sum = sum + 3'h4; // [RQ1]
    return sum; // three bits cannot exceed seven [RQ3]
  endfunction : pack_halls

  // one level as an ascii digit
  function automatic logic [7:0] digit_of(input logic level);
    return level ? (CHAR_ZERO + 8'h01) : CHAR_ZERO; // [RQ5]
  endfunction : digit_of

  // only encoder types that carry hall switches give readings
  function automatic logic has_halls(input logic [TYPE_W-1:0] code);
    return (code == TYPE_INC_HALL) || (code == TYPE_SINE_HALL); // [RQ6]
  endfunction : has_halls

  // one switch level as a byte wide register value
  function automatic logic [7:0] level_byte(input logic level);
    return {7'h00, level}; // [RQ7] [RQ8]
  endfunction : level_byte

  // byte registers sit in the low bits of a read word
  function automatic logic [DATA_W-1:0] widen_byte(input logic [7:0] value);
    return {{(DATA_W-8){1'b0}}, value};
  endfunction : widen_byte

  // text form with spaces between the three digits
  function automatic logic [TEXT_W-1:0] text_of(input logic [2:0] word);
    return {digit_of(word[BIT_U]), CHAR_SPACE,
            digit_of(word[BIT_V]), CHAR_SPACE,
            digit_of(word[BIT_W])}; // [RQ4] [RQ5]
  endfunction : text_of

  // text shown while no hall information is present
  localparam logic [TEXT_W-1:0] TEXT_IDLE = {CHAR_ZERO, CHAR_SPACE, CHAR_ZERO,
                                             CHAR_SPACE, CHAR_ZERO};

  // feedback type capture
  logic              type_loaded;
  logic              next_type_loaded;
  logic [TYPE_W-1:0] next_feedback_type_code;

  // caught once after reset release, never under the async reset itself
  always_comb begin
    next_type_loaded        = 1'b1;
    next_feedback_type_code = feedback_type_code;
    if (!type_loaded) begin
      if (feedback_type_selection == TYPE_SELECT_NONE) begin
        next_feedback_type_code = stored_feedback_type; // [RQ11]
      end else begin
        next_feedback_type_code = feedback_type_selection; // [RQ11] [RQ10]
      end
    end
  end

  // a later change of selection waits for the next reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      type_loaded        <= 1'b0;
      feedback_type_code <= TYPE_UNKNOWN;
    end else begin
      type_loaded        <= next_type_loaded;
      feedback_type_code <= next_feedback_type_code; // [RQ9]
    end
  end

  // hall state registers
  logic [2:0]        next_packed;
  logic [TEXT_W-1:0] next_text;
  logic [7:0]        next_u;
  logic [7:0]        next_v;
  logic [7:0]        next_w;
  logic              next_valid;
  logic              next_changed;
  logic              next_illegal;

  // without hall information the levels keep their default of one
  always_comb begin
    next_valid   = has_halls(feedback_type_code); // [RQ6]
    next_packed  = PACKED_RESET;
    next_u       = LEVEL_RESET;
    next_v       = LEVEL_RESET;
    next_w       = LEVEL_RESET;
    next_text    = TEXT_IDLE;
    next_illegal = 1'b0;
    if (next_valid) begin
      next_packed  = pack_halls(hall_sync[BIT_U], hall_sync[BIT_V], hall_sync[BIT_W]); // [RQ1]
      next_u       = level_byte(hall_sync[BIT_U]); // [RQ7]
      next_v       = level_byte(hall_sync[BIT_V]); // [RQ8]
      next_w       = level_byte(hall_sync[BIT_W]); // [RQ8]
      // first character is switch U, the leftmost on the string
      next_text    = text_of(hall_sync); // [RQ4] [RQ5]
      // 000 or 111 points at a broken wire or a missing sensor supply
      next_illegal = (hall_sync == HALL_ALL_LOW) || (hall_sync == HALL_ALL_HIGH);
    end

    // entering the valid state is not a change, but the sync chain still reads 000 then, so nonzero pins give one pulse after reset
    next_changed = hall_info_valid && next_valid &&
                   (next_packed != packed_commutation_switches);
  end

  // every hall output is a flop, so readers never see a glitch
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      packed_commutation_switches <= PACKED_RESET;
      hall_text                   <= TEXT_IDLE;
      switch_u_level              <= LEVEL_RESET;
      switch_v_level              <= LEVEL_RESET;
      switch_w_level              <= LEVEL_RESET;
      hall_info_valid             <= 1'b0;
      hall_changed                <= 1'b0;
      hall_illegal                <= 1'b0;
    end else begin
      packed_commutation_switches <= next_packed;
      hall_text                   <= next_text;
      switch_u_level              <= next_u;
      switch_v_level              <= next_v;
      switch_w_level              <= next_w;
      hall_info_valid             <= next_valid;
      hall_changed                <= next_changed;
      hall_illegal                <= next_illegal;
    end
  end

  // read port: registered answer one cycle after the request
  logic [DATA_W-1:0] next_rd_data;
  logic              next_rd_valid;
  logic              next_rd_error;

  // reads have no side effects, so a repeated read is always safe
  always_comb begin
    next_rd_data  = '0;
    next_rd_valid = rd_en;
    next_rd_error = 1'b0;
    if (rd_en) begin
      case (rd_addr)
        OFS_SWITCH_U: next_rd_data = widen_byte(switch_u_level); // [RQ7]
        OFS_SWITCH_V: next_rd_data = widen_byte(switch_v_level); // [RQ8]
        OFS_SWITCH_W: next_rd_data = widen_byte(switch_w_level); // [RQ8]
        OFS_FB_TYPE:  next_rd_data = widen_byte(feedback_type_code); // [RQ9]
        OFS_PACKED:   next_rd_data = widen_byte({5'h00, packed_commutation_switches}); // [RQ3]
        // the text is split over two words; the upper one holds the U digit
        OFS_TEXT_LO:  next_rd_data = hall_text[31:0]; // [RQ4]
        OFS_TEXT_HI:  next_rd_data = widen_byte(hall_text[39:32]); // [RQ4]
        default:      next_rd_error = 1'b1; // unmapped reads return zero
      endcase
    end
  end

  // the answer stands one cycle only; hold rd_en to read again
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_data  <= '0;
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
    end else begin
      rd_data  <= next_rd_data;
      rd_valid <= next_rd_valid;
      rd_error <= next_rd_error;
    end
  end

endmodule : hall_sensor_state_readout

`default_nettype wire

// ===== rtl/hall_sync2.sv
`timescale 1ns/100ps
`default_nettype none

module hall_sync2 #(
  parameter int WIDTH = 3
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : hall_sync2

`default_nettype wire

// ===== test/hall_sensor_state_readout_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module hall_sensor_state_readout_monitor
  import hall_pkg::*;
(
  input wire logic              clk,
  input wire logic              reset_n,
  input wire logic              hall_u,
  input wire logic              rd_en,
  input wire logic [15:0]       rd_addr,
  input wire logic [DATA_W-1:0] rd_data,
  input wire logic [2:0]        packed_commutation_switches,
  input wire logic [TEXT_W-1:0] hall_text,
  input wire logic [7:0]        switch_u_level,
  input wire logic [7:0]        switch_v_level,
  input wire logic [7:0]        switch_w_level,
  input wire logic [TYPE_W-1:0] feedback_type_code,
  input wire logic              hall_info_valid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [2:0]        lvl;
  logic [TEXT_W-1:0] txt;
  // ascii '0' is 7'h18 then the digit bit
  assign lvl = {switch_w_level[0], switch_v_level[0], switch_u_level[0]};
  assign txt = {7'h18, lvl[0], CHAR_SPACE, 7'h18, lvl[1], CHAR_SPACE, 7'h18, lvl[2]};
  packed_weight_a: assert property (hall_info_valid |-> packed_commutation_switches == lvl)
    else $error("packed mismatch");
  packed_idle_a: assert property (!hall_info_valid |-> packed_commutation_switches == 3'h0)
    else $error("packed not zero without halls");
  idle_default_a: assert property (!hall_info_valid |-> lvl == HALL_ALL_HIGH)
    else $error("levels not default");
  valid_type_a: assert property (hall_info_valid |-> feedback_type_code inside {8'h0A, 8'h14})
    else $error("valid on wrong type");
  // three valid cycles back so the sync chain is already filled
  pin_latency_a: assert property (hall_info_valid && $past(hall_info_valid, 3)
    |-> switch_u_level[0] == $past(hall_u, 3))
    else $error("pin latency wrong");
  text_form_a: assert property (hall_info_valid |-> hall_text == txt)
    else $error("text mismatch");
  text_idle_a: assert property (!hall_info_valid
    |-> hall_text == {CHAR_ZERO, CHAR_SPACE, CHAR_ZERO, CHAR_SPACE, CHAR_ZERO})
    else $error("text not idle without halls");
  level_span_a: assert property ((switch_u_level | switch_v_level | switch_w_level) <= 8'h01)
    else $error("level out of span");
  read_u_a: assert property (rd_en && rd_addr == OFS_SWITCH_U ##1 $stable(switch_u_level)
    |-> rd_data == {24'h000000, switch_u_level})
    else $error("u read wrong");
  read_type_a: assert property (rd_en && rd_addr == OFS_FB_TYPE
    |=> rd_data == {24'h000000, feedback_type_code})
    else $error("type read wrong");
endmodule : hall_sensor_state_readout_monitor
`default_nettype wire

// ===== test/hall_sensor_state_readout_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module hall_sensor_state_readout_tb_top;
  import hall_pkg::*;
  logic              clk, reset_n, rd_en, rd_valid, rd_error, hall_info_valid;
  wire logic         hall_u, hall_v, hall_w;
  logic [2:0]        pattern, pk;
  logic [7:0]        sel, sto, lu, lv, lw, code;
  logic [15:0]       rd_addr;
  logic [DATA_W-1:0] rd_data, d;
  logic [TEXT_W-1:0] hall_text;
  logic              e, chg, ill;
  int                bad_count, checked;
  hall_switch_model sw_u (.pattern, .hall_u, .hall_v, .hall_w);
  hall_sensor_state_readout dut_u (.clk, .reset_n, .hall_u, .hall_v, .hall_w,
    .feedback_type_selection(sel), .stored_feedback_type(sto), .rd_en, .rd_addr,
    .rd_data, .rd_valid, .rd_error, .packed_commutation_switches(pk), .hall_text,
    .switch_u_level(lu), .switch_v_level(lv), .switch_w_level(lw),
    .feedback_type_code(code), .hall_info_valid, .hall_changed(chg), .hall_illegal(ill));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic check(input logic [TEXT_W-1:0] seen, input logic [TEXT_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // selection inputs are only taken at the first edge after release
  task automatic do_reset(input logic [7:0] s, input logic [7:0] t);
    reset_n = 1'b0;
    sel = s;
    sto = t;
    repeat (10) @(negedge clk);
    check({lu, lv, lw, pk}, {LEVEL_RESET, LEVEL_RESET, LEVEL_RESET, PACKED_RESET});
    reset_n = 1'b1;
    repeat (6) @(negedge clk);
  endtask : do_reset
  task automatic rd(input logic [15:0] a);
    rd_en = 1'b1;
    rd_addr = a;
    @(negedge clk);
    check(rd_valid, 1'b1);
    d = rd_data;
    e = rd_error;
    rd_en = 1'b0;
    @(negedge clk);
    check(rd_valid, 1'b0);
  endtask : rd
  task automatic t_types();
    logic [7:0] c [3] = '{8'h0A, 8'h0B, 8'h14};
    foreach (c[i]) begin
      do_reset(c[i], 8'h00);
      rd(OFS_FB_TYPE);
      check({code, d}, {c[i], 24'h000000, c[i]});
    end
    do_reset(8'hFF, 8'h14);
    check(code, 8'h14);
  endtask : t_types
  task automatic t_sweep();
    do_reset(8'h0A, 8'h00);
    for (int p = 0; p < 8; p++) begin
      pattern = p[2:0];
      repeat (3) @(negedge clk);
      check({chg, ill}, {p != 0, (p == 0) || (p == 7)});
      repeat (2) @(negedge clk);
      check({chg, hall_info_valid, pk}, {2'b01, p[2:0]});
      check(hall_text, {7'h18, p[0], 8'h20, 7'h18, p[1], 8'h20, 7'h18, p[2]});
      rd(OFS_SWITCH_U);
      check(d, {31'h0, p[0]});
      rd(OFS_SWITCH_V);
      check(d, {31'h0, p[1]});
      rd(OFS_SWITCH_W);
      check(d, {31'h0, p[2]});
      rd(OFS_PACKED);
      check(d, {29'h0, p[2:0]});
      rd(OFS_TEXT_LO);
      check(d, {CHAR_SPACE, 7'h18, p[1], CHAR_SPACE, 7'h18, p[2]});
      rd(OFS_TEXT_HI);
      check(d, {24'h000000, 7'h18, p[0]});
    end
  endtask : t_sweep
  // no halls fitted: levels keep defaults, unmapped read refused
  task automatic t_invalid();
    pattern = 3'h5;
    do_reset(8'h0B, 8'h00);
    check({pk, lv}, {3'h0, 8'h01});
    check({hall_info_valid, chg, ill}, 3'h0);
    rd(16'h03A2);
    check({e, d}, {1'b1, 32'h0});
  endtask : t_invalid
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up
  initial begin
    bad_count = 0;
    checked = 0;
    reset_n = 1'b0;
    pattern = 3'h0;
    sel = 8'h0A;
    sto = 8'h00;
    rd_en = 1'b0;
    rd_addr = 16'h0000;
    t_types();
    t_sweep();
    t_invalid();
    wrap_up();
  end
  initial begin
    #200000;
    bad_count++;
    wrap_up();
  end
endmodule : hall_sensor_state_readout_tb_top
bind hall_sensor_state_readout hall_sensor_state_readout_monitor mon_u (.clk, .reset_n,
  .hall_u, .rd_en, .rd_addr, .rd_data, .packed_commutation_switches, .hall_text,
  .switch_u_level, .switch_v_level, .switch_w_level, .feedback_type_code, .hall_info_valid);
`default_nettype wire

// ===== test/hall_switch_model.sv
`timescale 1ns/100ps
`default_nettype none
module hall_switch_model (
  input  wire logic [2:0] pattern,
  output logic            hall_u,
  output logic            hall_v,
  output logic            hall_w
);
  // pins settle off the clock edge, as a real magnet edge would
  assign #3 {hall_w, hall_v, hall_u} = pattern;
endmodule : hall_switch_model
`default_nettype wire
